/* File: gpib_pkg.sv */
package gpib_pkg;

	// ==========================================================
	// Register map (byte addresses)
	localparam logic [7:0] ctrl_addr     = 8'h00;
	localparam logic [7:0] status_addr   = 8'h04;
	localparam logic [7:0] rx_addr       = 8'h08;
	localparam logic [7:0] tx_addr       = 8'h0c;
	localparam logic [7:0] spoll_addr    = 8'h10;

	// ==========================================================
	// Field positions
	localparam int ctrl_srq_bit          = 8;
	localparam int rx_eoi_bit            = 8;
	localparam int rx_valid_bit          = 9;
	localparam int tx_eoi_bit            = 8;
	localparam int spoll_rqs_bit         = 6;
	localparam int st_talker_bit         = 0;
	localparam int st_listener_bit       = 1;
	localparam int st_remote_bit         = 2;
	localparam int st_lockout_bit        = 3;
	localparam int st_spoll_bit          = 4;
	localparam int st_volts_bit          = 5;
	localparam int st_rx_valid_bit       = 6;
	localparam int st_tx_busy_bit        = 7;
	localparam int st_func_lsb           = 8;

	// ==========================================================
	// Reset values and limits
	localparam logic [4:0] addr_reset    = 5'h00;
	localparam logic [4:0] addr_max      = 5'h1e;
	localparam logic [3:0] func_reset    = 4'h1;
	localparam logic [3:0] func_volts    = 4'h0;
	localparam logic [7:0] spoll_reset   = 8'h00;

	// ==========================================================
	// Command groups and codes (7-bit)
	localparam logic [6:0] listen_base   = 7'h20;
	localparam logic [6:0] talk_base     = 7'h40;
	localparam logic [6:0] cmd_gtl       = 7'h01;
	localparam logic [6:0] cmd_sdc       = 7'h04;
	localparam logic [6:0] cmd_get       = 7'h08;
	localparam logic [6:0] cmd_llo       = 7'h11;
	localparam logic [6:0] cmd_dcl       = 7'h14;
	localparam logic [6:0] cmd_spe       = 7'h18;
	localparam logic [6:0] cmd_spd       = 7'h19;
	localparam logic [6:0] cmd_unl       = 7'h3f;
	localparam logic [6:0] cmd_unt       = 7'h5f;

	// Device-dependent command characters
	localparam logic [6:0] char_func     = 7'h46;
	localparam logic [6:0] char_exec     = 7'h58;
	localparam logic [6:0] char_zero     = 7'h30;
	localparam logic [6:0] char_nine     = 7'h39;

	typedef enum logic [2:0] {
		grp_addressed,
		grp_universal,
		grp_listen,
		grp_talk,
		grp_secondary
	} cmd_group_t;

	// AHB
	localparam logic [1:0] htrans_nonseq = 2'h2;
	localparam logic       hresp_okay    = 1'h0;

endpackage

/* File: byte_acceptor.sv */
module byte_acceptor
(
	// Clock and reset
	input  wire logic       mclk,
	input  wire logic       rst,
	// Control
	input  wire logic       active,
	input  wire logic       stall,
	// Bus lines, true level
	input  wire logic       dav_t,
	input  wire logic [7:0] dio_t,
	input  wire logic       eoi_t,
	input  wire logic       atn_t,
	// Handshake drive, enables low while pulling the line true
	output logic            nrfd_oe_n_q,
	output logic            ndac_oe_n_q,
	// Received byte
	output logic            got_q,
	output logic [7:0]      byte_q,
	output logic            eoi_q,
	output logic            atn_q
);

	typedef enum logic {acc_ready, acc_hold} acc_state_t;

	acc_state_t state_q;

	// ==========================================================
	// Interlocked acceptor handshake
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			state_q     <= acc_ready;
			nrfd_oe_n_q <= 1'b1;
			ndac_oe_n_q <= 1'b1;
			got_q       <= 1'b0;
			byte_q      <= 8'h00;
			eoi_q       <= 1'b0;
			atn_q       <= 1'b0;
		end
		else
		begin
			got_q <= 1'b0;
			if (!active)
			begin
				// Non-participants leave both lines released
				state_q     <= acc_ready;
				nrfd_oe_n_q <= 1'b1;
				ndac_oe_n_q <= 1'b1;
			end
			else
			begin
				unique case (state_q)
					acc_ready:
					begin
						ndac_oe_n_q <= 1'b0;
						nrfd_oe_n_q <= !stall;
						if (dav_t && nrfd_oe_n_q && !ndac_oe_n_q)
						begin
							byte_q      <= dio_t;
							eoi_q       <= eoi_t;
							atn_q       <= atn_t;
							got_q       <= 1'b1;
							nrfd_oe_n_q <= 1'b0;
							ndac_oe_n_q <= 1'b1;
							state_q     <= acc_hold;
						end
					end
					acc_hold:
					begin
						if (!dav_t)
						begin
							ndac_oe_n_q <= 1'b0;
							state_q     <= acc_ready;
						end
					end
				endcase
			end
		end
	end

endmodule

/* File: gpib_decoder.sv */
// What this block does
// - Attention, clear, remote lines are inputs only
// - Assert service request until condition serviced
// - EOI marks final byte both directions
// - Interface clear idles talker and listener
// - Remote enable makes device remote-eligible
// - Attention bytes decode as interface commands
// - Listener data bytes pass as device data
// - Universal commands act regardless of addressing
// - LLO sets local lockout flag
// - DCL clears settings to power-up defaults
// - SPE enters serial poll, talk returns status
// - SPD leaves serial poll mode
// - Addressed commands only while listen-addressed
// - SDC clears like DCL when addressed
// - GTL returns to local when addressed
// - GET gives one-cycle trigger when addressed
// - UNL returns device to listener idle
// - UNT returns device to talker idle
// - Decode seven bits, ignore eighth line
// - Classify commands by upper column bits
// - Secondary command group takes no action
// - Volts function string then execute selects volts
// - Listen address OR 20h, talk OR 40h
// - Primary address limited to 0..30
// - Three-wire interlocked byte handshake
// - All bus lines active low
//
// Implementation choices: the placing of the registers and the AHB-Lite slave port.
module gpib_decoder
(
	// Clock and reset
	input  wire logic        mclk,
	input  wire logic        rst,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic [31:0]      hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// Controller-only lines
	input  wire logic        atn_n,
	input  wire logic        ifc_n,
	input  wire logic        ren_n,
	// Data lines
	input  wire logic [7:0]  dio_in_n,
	output logic [7:0]       dio_out_n,
	output logic [7:0]       dio_oe_n,
	// End or identify
	input  wire logic        eoi_in_n,
	output logic             eoi_out_n,
	output logic             eoi_oe_n,
	// Service request
	input  wire logic        srq_in_n,
	output logic             srq_out_n,
	output logic             srq_oe_n,
	// Handshake
	input  wire logic        dav_in_n,
	output logic             dav_out_n,
	output logic             dav_oe_n,
	input  wire logic        nrfd_in_n,
	output logic             nrfd_out_n,
	output logic             nrfd_oe_n,
	input  wire logic        ndac_in_n,
	output logic             ndac_out_n,
	output logic             ndac_oe_n,
	// Device side
	output logic             dev_clear,
	output logic             trigger,
	output logic             lockout,
	output logic             remote,
	output logic             volts_mode
);

	// ==========================================================
	// Line levels (low means true)
	logic       atn_t;
	logic       ifc_t;
	logic       ren_t;
	logic       dav_t;
	logic       nrfd_t;
	logic       ndac_t;
	logic       eoi_t;
	logic [7:0] dio_t;

	always_comb
	begin
		atn_t  = !atn_n;
		ifc_t  = !ifc_n;
		ren_t  = !ren_n;
		dav_t  = !dav_in_n;
		nrfd_t = !nrfd_in_n;
		ndac_t = !ndac_in_n;
		eoi_t  = !eoi_in_n;
		dio_t  = ~dio_in_n;
	end

	// ==========================================================
	// State
	logic [4:0] paddr_q;
	logic       srq_req_q;
	logic [7:0] spoll_byte_q;
	logic       talker_q;
	logic       listener_q;
	logic       remote_q;
	logic       lockout_q;
	logic       spoll_q;
	logic       spoll_sent_q;
	logic [3:0] func_q;
	logic [1:0] parse_q;
	logic [3:0] parse_digit_q;
	logic [7:0] rx_byte_q;
	logic       rx_eoi_q;
	logic       rx_valid_q;
	logic [7:0] tx_byte_q;
	logic       tx_eoi_q;
	logic       tx_pend_q;
	logic       dev_clear_q;
	logic       trigger_q;

	// ==========================================================
	// Acceptor
	logic       acc_nrfd_oe_n;
	logic       acc_ndac_oe_n;
	logic       got;
	logic [7:0] got_byte;
	logic       got_eoi;
	logic       got_atn;

	byte_acceptor u_acc
	(
		.mclk        (mclk),
		.rst         (rst),
		.active      (atn_t || listener_q),
		.stall       (rx_valid_q && !atn_t),
		.dav_t       (dav_t),
		.dio_t       (dio_t),
		.eoi_t       (eoi_t),
		.atn_t       (atn_t),
		.nrfd_oe_n_q (acc_nrfd_oe_n),
		.ndac_oe_n_q (acc_ndac_oe_n),
		.got_q       (got),
		.byte_q      (got_byte),
		.eoi_q       (got_eoi),
		.atn_q       (got_atn)
	);

	assign nrfd_oe_n  = acc_nrfd_oe_n;
	assign ndac_oe_n  = acc_ndac_oe_n;
	assign nrfd_out_n = 1'b0;
	assign ndac_out_n = 1'b0;

	// ==========================================================
	// Command classification
	function automatic gpib_pkg::cmd_group_t group_of(input logic [6:0] c);
		unique case (c[6:4])
			3'h0:          group_of = gpib_pkg::grp_addressed;
			3'h1:          group_of = gpib_pkg::grp_universal;
			3'h2, 3'h3:    group_of = gpib_pkg::grp_listen;
			3'h4, 3'h5:    group_of = gpib_pkg::grp_talk;
			default:       group_of = gpib_pkg::grp_secondary;
		endcase
	endfunction

	logic [6:0]           cmd;
	gpib_pkg::cmd_group_t grp;
	logic                 is_cmd;
	logic                 is_data;
	logic                 my_listen;
	logic                 my_talk;
	logic                 other_talk;
	logic                 do_clear;

	always_comb
	begin
		cmd        = got_byte[6:0];
		grp        = group_of(cmd);
		is_cmd     = got && got_atn;
		is_data    = got && !got_atn && listener_q;
		my_listen  = is_cmd && (cmd == (gpib_pkg::listen_base | {2'h0, paddr_q}));
		my_talk    = is_cmd && (cmd == (gpib_pkg::talk_base | {2'h0, paddr_q}));
		other_talk = is_cmd && (grp == gpib_pkg::grp_talk) && !my_talk
			&& (cmd != gpib_pkg::cmd_unt);
		do_clear   = (is_cmd && cmd == gpib_pkg::cmd_dcl)
			|| (is_cmd && listener_q && cmd == gpib_pkg::cmd_sdc);
	end

	// ==========================================================
	// Addressing
	always_ff @(posedge mclk)
	begin
		if (rst || ifc_t)
		begin
			talker_q   <= 1'b0;
			listener_q <= 1'b0;
		end
		else
		begin
			if (my_listen)
				listener_q <= 1'b1;
			else if (is_cmd && cmd == gpib_pkg::cmd_unl)
				listener_q <= 1'b0;
			if (my_talk)
				talker_q <= 1'b1;
			else if (is_cmd && cmd == gpib_pkg::cmd_unt)
				talker_q <= 1'b0;
			else if (other_talk)
				talker_q <= 1'b0;
		end
	end

	// ==========================================================
	// Remote, lockout, serial poll
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			remote_q  <= 1'b0;
			lockout_q <= 1'b0;
			spoll_q   <= 1'b0;
		end
		else
		begin
			if (!ren_t)
			begin
				remote_q  <= 1'b0;
				lockout_q <= 1'b0;
			end
			else
			begin
				if (my_listen)
					remote_q <= 1'b1;
				else if (is_cmd && listener_q && cmd == gpib_pkg::cmd_gtl)
					remote_q <= 1'b0;
				if (is_cmd && cmd == gpib_pkg::cmd_llo)
					lockout_q <= 1'b1;
			end
			if (is_cmd && cmd == gpib_pkg::cmd_spe)
				spoll_q <= 1'b1;
			else if (is_cmd && cmd == gpib_pkg::cmd_spd)
				spoll_q <= 1'b0;
		end
	end

	// ==========================================================
	// Clear and trigger pulses
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			dev_clear_q <= 1'b0;
			trigger_q   <= 1'b0;
		end
		else
		begin
			dev_clear_q <= do_clear;
			trigger_q   <= is_cmd && listener_q && cmd == gpib_pkg::cmd_get;
		end
	end

	// ==========================================================
	// Device-dependent string parse; a message end abandons a partial string
	always_ff @(posedge mclk)
	begin
		if (rst || do_clear)
		begin
			func_q        <= gpib_pkg::func_reset;
			parse_q       <= 2'h0;
			parse_digit_q <= 4'h0;
		end
		else if (is_data)
		begin
			if (got_byte[6:0] == gpib_pkg::char_func)
				parse_q <= 2'h1;
			else if (parse_q == 2'h1 && got_byte[6:0] >= gpib_pkg::char_zero
				&& got_byte[6:0] <= gpib_pkg::char_nine)
			begin
				parse_q       <= 2'h2;
				parse_digit_q <= got_byte[3:0];
			end
			else if (parse_q == 2'h2 && got_byte[6:0] == gpib_pkg::char_exec)
			begin
				func_q  <= parse_digit_q;
				parse_q <= 2'h0;
			end
			else
				parse_q <= 2'h0;
			if (got_eoi)
				parse_q <= 2'h0;
		end
	end

	// ==========================================================
	// Receive holding register; a new byte wins over a read that clears it
	logic rx_pop;

	always_ff @(posedge mclk)
	begin
		if (rst || do_clear)
		begin
			rx_byte_q  <= 8'h00;
			rx_eoi_q   <= 1'b0;
			rx_valid_q <= 1'b0;
		end
		else if (is_data)
		begin
			rx_byte_q  <= got_byte;
			rx_eoi_q   <= got_eoi;
			rx_valid_q <= 1'b1;
		end
		else if (rx_pop)
			rx_valid_q <= 1'b0;
	end

	// ==========================================================
	// Source handshake for talker output
	typedef enum logic [1:0] {src_idle, src_wait_ready, src_wait_accept} src_state_t;

	src_state_t src_q;
	logic       src_go;
	logic [7:0] src_byte;
	logic       src_eoi;

	always_comb
	begin
		src_go   = talker_q && !atn_t && (spoll_q ? !spoll_sent_q : tx_pend_q);
		src_byte = spoll_q ? {spoll_byte_q[7], srq_req_q, spoll_byte_q[5:0]} : tx_byte_q;
		src_eoi  = spoll_q || tx_eoi_q;
	end

	always_ff @(posedge mclk)
	begin
		if (rst || atn_t || ifc_t)
		begin
			// Attention takes the bus away from the talker at once
			src_q     <= src_idle;
			dio_oe_n  <= 8'hff;
			dio_out_n <= 8'hff;
			eoi_oe_n  <= 1'b1;
			eoi_out_n <= 1'b1;
			dav_oe_n  <= 1'b1;
		end
		else
		begin
			unique case (src_q)
				src_idle:
				begin
					dio_oe_n <= 8'hff;
					eoi_oe_n <= 1'b1;
					dav_oe_n <= 1'b1;
					if (src_go)
					begin
						dio_out_n <= ~src_byte;
						dio_oe_n  <= ~src_byte;
						eoi_out_n <= 1'b0;
						eoi_oe_n  <= !src_eoi;
						src_q     <= src_wait_ready;
					end
				end
				src_wait_ready:
				begin
					if (!nrfd_t && ndac_t)
					begin
						dav_oe_n <= 1'b0;
						src_q    <= src_wait_accept;
					end
				end
				src_wait_accept:
				begin
					if (!ndac_t)
					begin
						dav_oe_n <= 1'b1;
						src_q    <= src_idle;
					end
				end
				default:
					src_q <= src_idle;
			endcase
		end
	end

	assign dav_out_n = 1'b0;

	logic src_done;

	always_comb
		src_done = (src_q == src_wait_accept) && !ndac_t && !atn_t && !ifc_t;

	always_ff @(posedge mclk)
	begin
		if (rst || my_talk)
			spoll_sent_q <= 1'b0;
		else if (src_done && spoll_q)
			spoll_sent_q <= 1'b1;
	end

	// ==========================================================
	// Service request, open drain
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			srq_out_n <= 1'b1;
			srq_oe_n  <= 1'b1;
		end
		else
		begin
			srq_out_n <= 1'b0;
			srq_oe_n  <= !srq_req_q;
		end
	end

	// ==========================================================
	// AHB-Lite slave, zero wait states
	logic       wr_pend_q;
	logic [7:0] wr_addr_q;
	logic       take;

	always_comb
		take = hsel && hready && (htrans == gpib_pkg::htrans_nonseq || htrans == 2'h3);

	assign rx_pop = take && !hwrite && haddr[7:0] == gpib_pkg::rx_addr;

	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			wr_pend_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= gpib_pkg::hresp_okay;
		end
		else
		begin
			wr_pend_q <= take && hwrite;
			wr_addr_q <= haddr[7:0];
			hreadyout <= 1'b1;
			hresp     <= gpib_pkg::hresp_okay;
		end
	end

	logic [31:0] status_word;

	always_comb
	begin
		status_word = 32'h0;
		status_word[gpib_pkg::st_talker_bit]   = talker_q;
		status_word[gpib_pkg::st_listener_bit] = listener_q;
		status_word[gpib_pkg::st_remote_bit]   = remote_q;
		status_word[gpib_pkg::st_lockout_bit]  = lockout_q;
		status_word[gpib_pkg::st_spoll_bit]    = spoll_q;
		status_word[gpib_pkg::st_volts_bit]    = func_q == gpib_pkg::func_volts;
		status_word[gpib_pkg::st_rx_valid_bit] = rx_valid_q;
		status_word[gpib_pkg::st_tx_busy_bit]  = tx_pend_q;
		status_word[gpib_pkg::st_func_lsb +: 4] = func_q;
	end

	always_ff @(posedge mclk)
	begin
		if (rst)
			hrdata <= 32'h0;
		else if (take && !hwrite)
		begin
			unique case (haddr[7:0])
				gpib_pkg::ctrl_addr:   hrdata <= {23'h0, srq_req_q, 3'h0, paddr_q};
				gpib_pkg::status_addr: hrdata <= status_word;
				gpib_pkg::rx_addr:     hrdata <= {22'h0, rx_valid_q, rx_eoi_q, rx_byte_q};
				gpib_pkg::spoll_addr:  hrdata <= {24'h0, spoll_byte_q};
				default:               hrdata <= 32'h0;
			endcase
		end
	end

	// Software registers; an out-of-range address write is dropped
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			paddr_q      <= gpib_pkg::addr_reset;
			srq_req_q    <= 1'b0;
			spoll_byte_q <= gpib_pkg::spoll_reset;
		end
		else if (wr_pend_q)
		begin
			if (wr_addr_q == gpib_pkg::ctrl_addr)
			begin
				if (hwdata[4:0] <= gpib_pkg::addr_max)
					paddr_q <= hwdata[4:0];
				srq_req_q <= hwdata[gpib_pkg::ctrl_srq_bit];
			end
			if (wr_addr_q == gpib_pkg::spoll_addr)
				spoll_byte_q <= hwdata[7:0];
		end
	end

	// Transmit holding register; a write while busy is ignored
	always_ff @(posedge mclk)
	begin
		if (rst || do_clear)
		begin
			tx_byte_q <= 8'h00;
			tx_eoi_q  <= 1'b0;
			tx_pend_q <= 1'b0;
		end
		else if (src_done && !spoll_q)
			tx_pend_q <= 1'b0;
		else if (wr_pend_q && wr_addr_q == gpib_pkg::tx_addr && !tx_pend_q)
		begin
			tx_byte_q <= hwdata[7:0];
			tx_eoi_q  <= hwdata[gpib_pkg::tx_eoi_bit];
			tx_pend_q <= 1'b1;
		end
	end

	// ==========================================================
	// Device outputs
	always_ff @(posedge mclk)
	begin
		if (rst)
		begin
			lockout    <= 1'b0;
			remote     <= 1'b0;
			volts_mode <= 1'b0;
		end
		else
		begin
			lockout    <= lockout_q;
			remote     <= remote_q;
			volts_mode <= func_q == gpib_pkg::func_volts;
		end
	end

	assign dev_clear = dev_clear_q;
	assign trigger   = trigger_q;

endmodule

/* File: gpib_decoder_chk.sv */
module gpib_decoder_chk
(
	// Clock and reset
	input  wire logic mclk,
	input  wire logic rst,
	// Watched ports
	input  wire logic hresp,
	input  wire logic hreadyout,
	input  wire logic atn_n,
	input  wire logic ifc_n,
	input  wire logic ren_n,
	input  wire logic dav_in_n,
	input  wire logic nrfd_in_n,
	input  wire logic ndac_in_n,
	input  wire logic dav_oe_n,
	input  wire logic nrfd_oe_n,
	input  wire logic ndac_oe_n,
	input  wire logic srq_oe_n,
	input  wire logic srq_out_n,
	input  wire logic trigger,
	input  wire logic dev_clear,
	input  wire logic lockout,
	input  wire logic remote
);
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// ==========
	// Answers, levels and pulses
	AST_OKAY: assert property (hreadyout && hresp == gpib_pkg::hresp_okay)
		else $error("bus answer stalled or not okay");
	AST_TRIG: assert property (trigger |=> !trigger)
		else $error("trigger longer than one cycle");
	AST_CLEAR: assert property (dev_clear |=> !dev_clear)
		else $error("device clear longer than one cycle");
	AST_REN: assert property (ren_n [*3] |-> !remote && !lockout)
		else $error("remote kept without remote enable");
	AST_SRQ: assert property (!srq_oe_n |-> !srq_out_n)
		else $error("service request driven high");
	// ==========
	// Handshake
	AST_ATN: assert property (!atn_n [*2] |-> dav_oe_n)
		else $error("source kept running under attention");
	AST_IFC: assert property (!ifc_n [*2] |-> dav_oe_n)
		else $error("source kept running under interface clear");
	AST_DAV: assert property ($fell(dav_oe_n) |-> $past(nrfd_in_n) && !$past(ndac_in_n))
		else $error("data valid before acceptors ready");
	AST_NDAC: assert property ($rose(ndac_oe_n) && !nrfd_oe_n |-> !$past(dav_in_n))
		else $error("accepted without data valid");
	AST_NRFD: assert property ($rose(nrfd_oe_n) |-> $past(dav_in_n))
		else $error("ready again while data valid");
endmodule
bind gpib_decoder gpib_decoder_chk i_gpib_decoder_chk (.mclk(mclk), .rst(rst), .hresp(hresp),
	.hreadyout(hreadyout), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n), .dav_in_n(dav_in_n),
	.nrfd_in_n(nrfd_in_n), .ndac_in_n(ndac_in_n), .dav_oe_n(dav_oe_n), .nrfd_oe_n(nrfd_oe_n),
	.ndac_oe_n(ndac_oe_n), .srq_oe_n(srq_oe_n), .srq_out_n(srq_out_n), .trigger(trigger),
	.dev_clear(dev_clear), .lockout(lockout), .remote(remote));

/* File: gpib_ctl_model.sv */
module gpib_ctl_model
(
	// Clock
	input  wire logic       mclk,
	// Resolved bus levels
	input  wire logic [7:0] dio_w,
	input  wire logic       eoi_w,
	input  wire logic       dav_w,
	input  wire logic       ndac_w,
	input  wire logic       nrfd_w,
	// Controller drive, high when released
	output logic            atn_n,
	output logic            ifc_n,
	output logic            ren_n,
	output logic [7:0]      m_dio,
	output logic            m_eoi,
	output logic            m_dav,
	output logic            m_nrfd,
	output logic            m_ndac
);
	logic       dav_p = 1'b1;
	logic [7:0] rx_b = 8'h00;
	logic       rx_e = 1'b0;
	int         rx_n = 0;
	int         lag = 0;
	int         cnt = 0;
	initial
	begin
		{atn_n, ifc_n, ren_n, m_dio, m_eoi, m_dav, m_nrfd, m_ndac} = '1;
	end
	// ==========
	// Controller-only lines
	task set(input logic a, input logic i, input logic r);
		atn_n <= a;
		ifc_n <= i;
		ren_n <= r;
	endtask
	// ==========
	// Source side
	task send(input logic atn, input logic [7:0] b, input logic e);
		@(posedge mclk);
		atn_n <= !atn;
		m_dio <= ~b;
		m_eoi <= !e;
		// Acceptors need settling time after attention changes
		repeat (3) @(posedge mclk);
		while (!(nrfd_w && !ndac_w)) @(posedge mclk);
		m_dav <= 1'b0;
		do @(posedge mclk); while (!ndac_w);
		m_dav <= 1'b1;
		@(posedge mclk);
		m_dio <= '1;
		m_eoi <= 1'b1;
	endtask
	// ==========
	// Acceptor side; lag slows the release of NDAC
	always @(posedge mclk)
	begin
		m_nrfd <= dav_w;
		if (dav_w)
		begin
			cnt <= 0;
			m_ndac <= 1'b0;
		end
		else if (cnt < lag)
			cnt <= cnt + 1;
		else
			m_ndac <= 1'b1;
		if (!dav_w && dav_p)
		begin
			rx_b <= ~dio_w;
			rx_e <= !eoi_w;
			rx_n <= rx_n + 1;
		end
		dav_p <= dav_w;
	end
endmodule

/* File: tb_top.sv */
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam logic [4:0] pa = 5'h05;
	localparam logic [6:0] la = gpib_pkg::listen_base | {2'h0, pa};
	localparam logic [6:0] ta = gpib_pkg::talk_base | {2'h0, pa};
	localparam logic [7:0] sp = 8'h81;
	localparam logic [7:0] st = gpib_pkg::status_addr;
	logic        mclk = 1'b0;
	logic        rst = 1'b1;
	logic        hsel = 1'b0;
	logic        hwrite = 1'b0;
	logic [1:0]  htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata;
	logic        hreadyout, hresp, atn_n, ifc_n, ren_n;
	logic [7:0]  dio_w, m_dio, dio_out_n, dio_oe_n;
	logic        eoi_w, m_eoi, eoi_out_n, eoi_oe_n, srq_w, srq_out_n, srq_oe_n;
	logic        dav_w, m_dav, dav_out_n, dav_oe_n, nrfd_w, m_nrfd, nrfd_out_n, nrfd_oe_n;
	logic        ndac_w, m_ndac, ndac_out_n, ndac_oe_n;
	logic        dev_clear, trigger, lockout, remote, volts_mode;
	int          num_errors = 0;
	int          n_tests = 0;
	int          n_trig = 0;
	int          n_clr = 0;
	// ==========
	// Bus lines are pulled up; any party pulling low wins
	assign dio_w = m_dio & (dio_oe_n | dio_out_n);
	assign eoi_w = m_eoi & (eoi_oe_n | eoi_out_n);
	assign srq_w = srq_oe_n | srq_out_n;
	assign dav_w = m_dav & (dav_oe_n | dav_out_n);
	assign nrfd_w = m_nrfd & (nrfd_oe_n | nrfd_out_n);
	assign ndac_w = m_ndac & (ndac_oe_n | ndac_out_n);
	gpib_decoder i_gpib_decoder (.mclk(mclk), .rst(rst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .atn_n(atn_n), .ifc_n(ifc_n),
		.ren_n(ren_n), .dio_in_n(dio_w), .dio_out_n(dio_out_n), .dio_oe_n(dio_oe_n),
		.eoi_in_n(eoi_w), .eoi_out_n(eoi_out_n), .eoi_oe_n(eoi_oe_n), .srq_in_n(srq_w),
		.srq_out_n(srq_out_n), .srq_oe_n(srq_oe_n), .dav_in_n(dav_w), .dav_out_n(dav_out_n),
		.dav_oe_n(dav_oe_n), .nrfd_in_n(nrfd_w), .nrfd_out_n(nrfd_out_n), .nrfd_oe_n(nrfd_oe_n),
		.ndac_in_n(ndac_w), .ndac_out_n(ndac_out_n), .ndac_oe_n(ndac_oe_n),
		.dev_clear(dev_clear), .trigger(trigger), .lockout(lockout), .remote(remote),
		.volts_mode(volts_mode));
	gpib_ctl_model i_gpib_ctl_model (.mclk(mclk), .dio_w(dio_w), .eoi_w(eoi_w), .dav_w(dav_w),
		.ndac_w(ndac_w), .nrfd_w(nrfd_w), .atn_n(atn_n), .ifc_n(ifc_n), .ren_n(ren_n),
		.m_dio(m_dio), .m_eoi(m_eoi), .m_dav(m_dav), .m_nrfd(m_nrfd), .m_ndac(m_ndac));
	initial
	begin
		forever #20 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		if (trigger === 1'b1) n_trig++;
		if (dev_clear === 1'b1) n_clr++;
	end
	// ==========
	// Shared tasks
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			num_errors++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		hsel <= 1'b1;
		htrans <= gpib_pkg::htrans_nonseq;
		haddr <= {24'h0, a};
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		ahb(1'b1, a, d, x);
	endtask
	task rdc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0, d);
		chk(d & m, e);
	endtask
	task tx(input logic a, input logic [7:0] b, input logic e);
		i_gpib_ctl_model.send(a, b, e);
		repeat (2) @(posedge mclk);
	endtask
	task cmd(input logic [6:0] c);
		tx(1'b1, {1'b0, c}, 1'b0);
	endtask
	task wait_rx;
		int n0;
		n0 = i_gpib_ctl_model.rx_n;
		for (int k = 0; k < 300 && i_gpib_ctl_model.rx_n == n0; k++) @(posedge mclk);
	endtask
	// ==========
	// Scenarios
	task t_reset;
		rdc(st, 32'hfff, 32'h100);
		rdc(8'h20, 32'hffffffff, 32'h0);
		chk({29'h0, remote, lockout, volts_mode}, 32'h0);
		wr(gpib_pkg::ctrl_addr, 32'h1f);
		rdc(gpib_pkg::ctrl_addr, 32'h1f, 32'h0);
	endtask
	task t_addr;
		wr(gpib_pkg::ctrl_addr, {27'h0, pa});
		i_gpib_ctl_model.set(1'b1, 1'b1, 1'b0);
		tx(1'b1, {1'b1, la}, 1'b0);
		rdc(st, 32'h7, 32'h6);
		cmd(gpib_pkg::cmd_get);
		chk(n_trig, 1);
		cmd(gpib_pkg::cmd_unl);
		rdc(st, 32'h7, 32'h4);
		cmd(gpib_pkg::cmd_get);
		chk(n_trig, 1);
	endtask
	task t_univ;
		cmd(gpib_pkg::cmd_llo);
		chk({31'h0, lockout}, 32'h1);
		cmd(gpib_pkg::cmd_sdc);
		chk(n_clr, 0);
		cmd(gpib_pkg::cmd_dcl);
		chk(n_clr, 1);
		cmd(la);
		cmd(gpib_pkg::cmd_sdc);
		chk(n_clr, 2);
		cmd(gpib_pkg::cmd_gtl);
		chk({31'h0, remote}, 32'h0);
	endtask
	task t_data;
		logic [6:0] s [3] = '{gpib_pkg::char_func, gpib_pkg::char_zero, gpib_pkg::char_exec};
		for (int i = 0; i < 3; i++)
		begin
			tx(1'b0, {1'b0, s[i]}, i == 2);
			rdc(gpib_pkg::rx_addr, 32'h3ff, {22'h0, 1'b1, i == 2, 1'b0, s[i]});
		end
		chk({31'h0, volts_mode}, 32'h1);
		cmd(gpib_pkg::cmd_unl);
		tx(1'b0, 8'h5a, 1'b0);
		rdc(gpib_pkg::rx_addr, 32'h200, 32'h0);
	endtask
	task t_talk;
		cmd(ta);
		rdc(st, 32'h1, 32'h1);
		cmd(ta + 7'h01);
		rdc(st, 32'h1, 32'h0);
		cmd(ta);
		cmd(gpib_pkg::cmd_unt);
		rdc(st, 32'h1, 32'h0);
		cmd(ta);
		cmd(la);
		cmd(7'h65);
		rdc(st, 32'h3, 32'h3);
		i_gpib_ctl_model.set(1'b0, 1'b0, 1'b0);
		repeat (2) @(posedge mclk);
		i_gpib_ctl_model.set(1'b0, 1'b1, 1'b0);
		rdc(st, 32'h3, 32'h0);
	endtask
	task t_spoll;
		wr(gpib_pkg::spoll_addr, {24'h0, sp});
		wr(gpib_pkg::ctrl_addr, 32'h100 | pa);
		repeat (2) @(posedge mclk);
		chk({31'h0, srq_w}, 32'h0);
		cmd(gpib_pkg::cmd_spe);
		cmd(ta);
		// A slow listener: the talker must hold data valid meanwhile
		i_gpib_ctl_model.lag = 3;
		i_gpib_ctl_model.set(1'b1, 1'b1, 1'b0);
		wait_rx();
		chk({23'h0, i_gpib_ctl_model.rx_e, i_gpib_ctl_model.rx_b}, {23'h1, sp | 8'h40});
		cmd(gpib_pkg::cmd_spd);
		rdc(st, 32'h10, 32'h0);
		wr(gpib_pkg::tx_addr, 32'h141);
		i_gpib_ctl_model.set(1'b1, 1'b1, 1'b0);
		wait_rx();
		chk({23'h0, i_gpib_ctl_model.rx_e, i_gpib_ctl_model.rx_b}, 32'h141);
		wr(gpib_pkg::ctrl_addr, {27'h0, pa});
		repeat (2) @(posedge mclk);
		chk({31'h0, srq_w}, 32'h1);
		i_gpib_ctl_model.set(1'b1, 1'b1, 1'b1);
		repeat (3) @(posedge mclk);
		chk({30'h0, remote, lockout}, 32'h0);
	endtask
	task conclude;
		if (num_errors == 0 && n_tests > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	initial
	begin
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset();
		t_addr();
		t_univ();
		t_data();
		t_talk();
		t_spoll();
		conclude();
	end
	initial
	begin
		repeat (50000) @(posedge mclk);
		num_errors++;
		conclude();
	end
endmodule
